/* inc/shutdown_consts.svh */
// constants for the shutdown write sequencer
`ifndef SHUTDOWN_CONSTS_SVH
`define SHUTDOWN_CONSTS_SVH

// ===========================================================
// register indices (byte address is four times the index)
`define REG_LAUNCH 8'h6F
`define REG_STATUS 8'h70
`define REG_BIAS 8'h04
`define REG_MIDRAIL 8'h05
`define REG_PHONES_GAIN 8'h0E
`define REG_LINE_GAIN 8'h0F
`define REG_CONVERTERS 8'h12
`define REG_CLOCKS 8'h16
`define REG_SERVO 8'h43
`define REG_PHONES_OUT 8'h5A
`define REG_LINE_OUT 8'h5E
`define REG_CHARGE_PUMP 8'h62
`define REG_DUMMY 8'hFF

// ===========================================================
// control register slots
`define N_CTRL 10
`define SLOT_W 4
`define SLOT_NONE 4'hF
`define SLOT_BIAS 4'h0
`define SLOT_MIDRAIL 4'h1
`define SLOT_PHONES_GAIN 4'h2
`define SLOT_LINE_GAIN 4'h3
`define SLOT_CONVERTERS 4'h4
`define SLOT_CLOCKS 4'h5
`define SLOT_SERVO 4'h6
`define SLOT_PHONES_OUT 4'h7
`define SLOT_LINE_OUT 4'h8
`define SLOT_CHARGE_PUMP 4'h9
`define CTRL_RESET 16'h0000

// ===========================================================
// field positions
`define LAUNCH_START_BIT 8
`define LAUNCH_INDEX_MSB 6
`define STATUS_BUSY_BIT 0
`define STATUS_INDEX_LSB 8
`define STATUS_INDEX_MSB 14
`define BIAS_ON_BIT 0
`define MIDRAIL_ON_BIT 0
`define MIDRAIL_DIV_LSB 1
`define MIDRAIL_DIV_MSB 2
`define MIDRAIL_BUF_BIT 6
`define CONV_RIGHT_BIT 2
`define CONV_LEFT_BIT 3
`define CLOCK_GATE_BIT 1
`define CHARGE_PUMP_BIT 0
`define SERVO_MSB 3
`define GAIN_MSB 1
`define STAGE_MSB 7

// ===========================================================
// list and timing
`define SHUTDOWN_FIRST 7'h19
`define SEQ_TICK_NS 62500
`define CLK_PERIOD_NS 40
`define DELAY_OFFSET 64'h8
`define HSIZE_WORD 3'b010
`define HRESP_OKAY 1'b0

`endif

/* inc/shutdown_pkg.sv */
// types for the shutdown write sequencer
package shutdown_pkg;

	typedef enum logic [1:0] {S_IDLE, S_APPLY, S_WAIT} seq_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [2:0] width_m1;
		logic [3:0] start;
		logic [7:0] data;
		logic [3:0] delay;
		logic list_end_flag;
	} seq_entry_t;

endpackage

/* rtl/delay_timer.sv */
// down counter that times one sequencer wait
`include "shutdown_consts.svh"
module delay_timer #(
	parameter int CNT_W = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic load,
	input wire logic [CNT_W-1:0] load_cycles,
	output logic expired
);

	logic [CNT_W-1:0] count;
	logic running;

	// last cycle of the wait
	assign expired = running && (count == CNT_W'(1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			running <= 1'b0;
		end else if (ce) begin
			if (load) begin
				count <= load_cycles;
				running <= 1'b1;
			end else if (running) begin
				count <= count - CNT_W'(1);
				running <= !expired;
			end
		end
	end

endmodule

/* rtl/shutdown_write_sequencer.sv */
// shutdown write sequencer with its control registers and AHB-Lite slave
// Function
// - launch starts list execution at entry 25, not zero.
// - entries run one after another without host help until end flag.
// - with 25MHz clock the whole list takes about 296ms.
// - entries 25,26 write 77h to 5Eh then 5Ah, 0.5625ms waits.
// - entries 27,28 write 00h to 5Ah then 5Eh.
// - entry 29 clears four servo lane enables in 43h.
// - entry 30 clears charge pump bit 0 of 62h.
// - entry 31 clears two converter bits from bit 2 of 12h.
// - entry 32 clears processing clock gate bit 1 of 16h.
// - entries 33,34 clear gain stage pairs in 0Eh then 0Fh.
// - entry 35 clears bias bit 0 of 04h.
// - entry 36 clears reference bit 0 of 05h, delay code Ch.
// - entry 37 clears bit 0 of 05h again, delay code 9h.
// - entry 38 writes 00h to low byte of 05h.
// - entry 39 clears two bits of 04h and ends the list.
// - busy flag is 1 while the list runs, 0 after.
//
// The AHB-Lite slave port was left to the implementer.
`include "shutdown_consts.svh"
module shutdown_write_sequencer
	import shutdown_pkg::*;
#(
	parameter int TWO_TICK_CYCLES = 2 * `SEQ_TICK_NS / `CLK_PERIOD_NS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic sequencer_running_flag,
	output logic bias_generator_on,
	output logic midrail_reference_on,
	output logic [1:0] midrail_divider_select,
	output logic midrail_buffer_on,
	output logic [1:0] phones_gain_stages_on,
	output logic [1:0] line_gain_stages_on,
	output logic left_converter_on,
	output logic right_converter_on,
	output logic processing_clock_gate,
	output logic [3:0] offset_servo_lanes_on,
	output logic [7:0] phones_stage_ctrl,
	output logic [7:0] line_stage_ctrl,
	output logic charge_pump_on
);

	// ===========================================================
	// stored shutdown list
	function automatic seq_entry_t list_entry(input logic [6:0] idx);
		seq_entry_t e;
		e = '{`REG_DUMMY, 3'h0, 4'h0, 8'h00, 4'h0, 1'b1};
		case (idx)
			7'd25: e = '{`REG_LINE_OUT, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0};
			7'd26: e = '{`REG_PHONES_OUT, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0};
			7'd27: e = '{`REG_PHONES_OUT, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0};
			7'd28: e = '{`REG_LINE_OUT, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0};
			7'd29: e = '{`REG_SERVO, 3'h3, 4'h0, 8'h00, 4'h0, 1'b0};
			7'd30: e = '{`REG_CHARGE_PUMP, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0};
			7'd31: e = '{`REG_CONVERTERS, 3'h1, 4'h2, 8'h00, 4'h0, 1'b0};
			7'd32: e = '{`REG_CLOCKS, 3'h0, 4'h1, 8'h00, 4'h0, 1'b0};
			7'd33: e = '{`REG_PHONES_GAIN, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0};
			7'd34: e = '{`REG_LINE_GAIN, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0};
			7'd35: e = '{`REG_BIAS, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0};
			7'd36: e = '{`REG_MIDRAIL, 3'h0, 4'h0, 8'h00, 4'hC, 1'b0};
			7'd37: e = '{`REG_MIDRAIL, 3'h0, 4'h0, 8'h00, 4'h9, 1'b0};
			7'd38: e = '{`REG_MIDRAIL, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0};
			7'd39: e = '{`REG_BIAS, 3'h1, 4'h0, 8'h00, 4'h0, 1'b1};
			default: e = '{`REG_DUMMY, 3'h0, 4'h0, 8'h00, 4'h0, 1'b1};
		endcase
		return e;
	endfunction

	// register index to control slot
	function automatic logic [`SLOT_W-1:0] slot_of(input logic [7:0] idx);
		logic [`SLOT_W-1:0] s;
		s = `SLOT_NONE;
		case (idx)
			`REG_BIAS: s = `SLOT_BIAS;
			`REG_MIDRAIL: s = `SLOT_MIDRAIL;
			`REG_PHONES_GAIN: s = `SLOT_PHONES_GAIN;
			`REG_LINE_GAIN: s = `SLOT_LINE_GAIN;
			`REG_CONVERTERS: s = `SLOT_CONVERTERS;
			`REG_CLOCKS: s = `SLOT_CLOCKS;
			`REG_SERVO: s = `SLOT_SERVO;
			`REG_PHONES_OUT: s = `SLOT_PHONES_OUT;
			`REG_LINE_OUT: s = `SLOT_LINE_OUT;
			`REG_CHARGE_PUMP: s = `SLOT_CHARGE_PUMP;
			default: s = `SLOT_NONE;
		endcase
		return s;
	endfunction

	// ===========================================================
	// state
	logic [15:0] ctrl [`N_CTRL];
	seq_state_t state;
	seq_state_t next_state;
	logic [6:0] cur_index;
	logic [6:0] next_index;
	logic [6:0] launch_index;
	logic wr_pend;
	logic [7:0] wr_index;
	logic rd_pend;
	logic [7:0] rd_index;
	logic timer_done;

	// ===========================================================
	// bus address phase decode
	wire addr_take = hsel && hready && htrans[1];
	wire addr_word = (hsize == `HSIZE_WORD) && (haddr[1:0] == 2'b00) && (haddr[31:10] == '0);
	wire [7:0] addr_index = haddr[9:2];

	// bus data phase decode
	wire [`SLOT_W-1:0] bus_slot = slot_of(wr_index);
	wire bus_ctrl_wr = wr_pend && (bus_slot != `SLOT_NONE);
	wire launch_wr = wr_pend && (wr_index == `REG_LAUNCH);
	wire launch_req = launch_wr && hwdata[`LAUNCH_START_BIT];
	wire [6:0] req_index = hwdata[`LAUNCH_INDEX_MSB:0];

	// ===========================================================
	// current entry and its read-modify-write
	wire seq_entry_t entry = list_entry(cur_index);
	wire [`SLOT_W-1:0] seq_slot = slot_of(entry.addr);
	wire seq_slot_ok = seq_slot != `SLOT_NONE;
	wire seq_wr = (state == S_APPLY) && seq_slot_ok;
	wire [15:0] seq_old = seq_slot_ok ? ctrl[seq_slot] : `CTRL_RESET;
	wire [3:0] field_len = {1'b0, entry.width_m1} + 4'h1;
	wire [15:0] field_ones = ~(16'hFFFF << field_len);
	wire [15:0] field_mask = field_ones << entry.start;
	wire [15:0] field_data = {8'h00, entry.data} << entry.start;
	wire [15:0] seq_new = (seq_old & ~field_mask) | (field_data & field_mask);

	// wait length: (2^n + 8) ticks of 62.5us, rounded up to whole cycles
	wire [63:0] delay_full = (((64'h1 << entry.delay) + `DELAY_OFFSET)
		* 64'(TWO_TICK_CYCLES)) + 64'h1;
	wire [31:0] delay_cycles = delay_full[32:1];

	// ===========================================================
	// sequencer next state
	always_comb begin
		next_state = state;
		next_index = cur_index;
		unique case (state)
			S_IDLE: begin
				if (launch_req) begin
					next_state = S_APPLY;
					next_index = req_index;
				end
			end
			S_APPLY: begin
				next_state = S_WAIT;
			end
			S_WAIT: begin
				if (timer_done) begin
					if (entry.list_end_flag) begin
						next_state = S_IDLE;
					end else begin
						next_state = S_APPLY;
						next_index = cur_index + 7'h1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			cur_index <= '0;
		end else if (ce) begin
			state <= next_state;
			cur_index <= next_index;
		end
	end

	delay_timer #(
		.CNT_W(32)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.load(state == S_APPLY),
		.load_cycles(delay_cycles),
		.expired(timer_done)
	);

	// ===========================================================
	// control registers: sequencer write wins over a bus write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `N_CTRL; i++) begin
				ctrl[i] <= `CTRL_RESET;
			end
		end else if (ce) begin
			for (int i = 0; i < `N_CTRL; i++) begin
				if (seq_wr && (seq_slot == `SLOT_W'(i))) begin
					ctrl[i] <= seq_new;
				end else if (bus_ctrl_wr && (bus_slot == `SLOT_W'(i))) begin
					ctrl[i] <= hwdata[15:0];
				end
			end
		end
	end

	// ===========================================================
	// bus slave: writes zero wait, reads one wait state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend <= 1'b0;
			wr_index <= '0;
			rd_pend <= 1'b0;
			rd_index <= '0;
			launch_index <= '0;
		end else if (ce) begin
			wr_pend <= addr_take && hwrite && addr_word;
			rd_pend <= addr_take && !hwrite;
			wr_index <= addr_index;
			rd_index <= addr_word ? addr_index : `REG_DUMMY;
			if (launch_wr) begin
				launch_index <= req_index;
			end
		end
	end

	wire [`SLOT_W-1:0] rd_slot = slot_of(rd_index);
	wire [15:0] status_word = {1'b0, cur_index, 7'h00, sequencer_running_flag};
	wire [31:0] read_value = (rd_index == `REG_LAUNCH) ? {25'h0, launch_index} :
		(rd_index == `REG_STATUS) ? {16'h0000, status_word} :
		(rd_slot != `SLOT_NONE) ? {16'h0000, ctrl[rd_slot]} : 32'h0000_0000;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (ce && rd_pend) begin
			hrdata <= read_value;
		end
	end

	assign hreadyout = !rd_pend;
	assign hresp = `HRESP_OKAY;

	// ===========================================================
	// outputs
	assign sequencer_running_flag = (state != S_IDLE);
	assign bias_generator_on = ctrl[`SLOT_BIAS][`BIAS_ON_BIT];
	assign midrail_reference_on = ctrl[`SLOT_MIDRAIL][`MIDRAIL_ON_BIT];
	assign midrail_divider_select = ctrl[`SLOT_MIDRAIL][`MIDRAIL_DIV_MSB:`MIDRAIL_DIV_LSB];
	assign midrail_buffer_on = ctrl[`SLOT_MIDRAIL][`MIDRAIL_BUF_BIT];
	assign phones_gain_stages_on = ctrl[`SLOT_PHONES_GAIN][`GAIN_MSB:0];
	assign line_gain_stages_on = ctrl[`SLOT_LINE_GAIN][`GAIN_MSB:0];
	assign left_converter_on = ctrl[`SLOT_CONVERTERS][`CONV_LEFT_BIT];
	assign right_converter_on = ctrl[`SLOT_CONVERTERS][`CONV_RIGHT_BIT];
	assign processing_clock_gate = ctrl[`SLOT_CLOCKS][`CLOCK_GATE_BIT];
	assign offset_servo_lanes_on = ctrl[`SLOT_SERVO][`SERVO_MSB:0];
	assign phones_stage_ctrl = ctrl[`SLOT_PHONES_OUT][`STAGE_MSB:0];
	assign line_stage_ctrl = ctrl[`SLOT_LINE_OUT][`STAGE_MSB:0];
	assign charge_pump_on = ctrl[`SLOT_CHARGE_PUMP][`CHARGE_PUMP_BIT];

	// ===========================================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [31:0] wait_len;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_len <= '0;
		end else if (ce) begin
			wait_len <= (state == S_WAIT) ? wait_len + 32'h1 : '0;
		end
	end

	sequence launch_taken;
		ce && (state == S_IDLE) && launch_req;
	endsequence

	sequence wait_over;
		ce && (state == S_WAIT) && timer_done;
	endsequence

	launch_start_a: assert property (launch_taken |=>
		(state == S_APPLY) && (cur_index == $past(req_index)))
		else $error("launch did not start at requested entry");

	busy_rise_a: assert property ($rose(sequencer_running_flag) |->
		$past(launch_req) && $past(ce))
		else $error("busy rose without a launch");

	step_next_a: assert property ((wait_over and !entry.list_end_flag) |=>
		(state == S_APPLY) && (cur_index == $past(cur_index) + 7'h1))
		else $error("sequencer did not advance to next entry");

	end_stop_a: assert property ((wait_over and entry.list_end_flag) |=>
		!sequencer_running_flag)
		else $error("sequencer did not stop on end flag");

	field_write_a: assert property ((ce && seq_wr) |=>
		ctrl[$past(seq_slot)] == $past(seq_new))
		else $error("entry field not written");

	wait_length_a: assert property (wait_over |->
		(wait_len + 32'h1) == delay_cycles)
		else $error("wait length differs from delay code");

	wait_hold_a: assert property ((ce && (state == S_WAIT) && !timer_done) |=>
		(state == S_WAIT) && $stable(cur_index))
		else $error("entry left before delay expired");

	apply_once_a: assert property ((ce && (state == S_APPLY)) |=>
		(state == S_WAIT) ##0 !(ce && seq_wr))
		else $error("entry write not followed by its delay");

	busy_ignore_a: assert property ((ce && (state != S_IDLE) && launch_req) |=>
		state != S_IDLE)
		else $error("launch disturbed a running list");

	read_wait_a: assert property ((ce && addr_take && !hwrite) |=>
		!hreadyout ##1 hreadyout)
		else $error("read answer not after one wait state");

	wire bus_only_wr = bus_ctrl_wr && !(seq_wr && (seq_slot == bus_slot));

	bus_write_a: assert property ((ce && bus_only_wr) |=>
		ctrl[$past(bus_slot)] == $past(hwdata[15:0]))
		else $error("bus write to control register lost");

	read_data_a: assert property ((ce && rd_pend) |=>
		hrdata == $past(read_value))
		else $error("read data not loaded");

	idle_hold_a: assert property ((ce && (state == S_IDLE) && !launch_req) |=>
		state == S_IDLE)
		else $error("sequencer started without a launch");

endmodule

/* test/host_bus_model.sv */
// host processor model driving the register bus
`include "shutdown_consts.svh"
module host_bus_model (
	input wire logic clk,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	bit hung = 1'b0;

	initial begin
		hsel <= 1'b0;
		haddr <= 32'h0;
		htrans <= 2'b00;
		hwrite <= 1'b0;
		hsize <= `HSIZE_WORD;
		hwdata <= 32'h0;
	end

	// ===========================================================
	// single word transfer, bounded waits on hready
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
		output logic [31:0] rd);
		int k;
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= `HSIZE_WORD;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 100);
		if (hreadyout !== 1'b1)
			hung = 1'b1;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {16'h0, wd};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 100);
		rd = hrdata;
		if (hreadyout !== 1'b1)
			hung = 1'b1;
	endtask

	// ===========================================================
	// one write launches the shutdown list
	task automatic launch;
		logic [31:0] d;
		xfer(1'b1, `REG_LAUNCH, 16'h0119, d);
	endtask
endmodule

/* test/shutdown_write_sequencer_tb_top.sv */
// testbench for the shutdown write sequencer
`include "shutdown_consts.svh"
module shutdown_write_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TT = 2;
	logic clk, rst_n, hsel, hwrite, hreadyout, hresp, busy_f, bias, mref, mbuf, conv_l, conv_r;
	logic pgate, cpump;
	logic [1:0] htrans, mdiv, pgain, lgain;
	logic [2:0] hsize;
	logic [3:0] servo;
	logic [7:0] pstage, lstage;
	logic [31:0] haddr, hwdata, hrdata;
	int n_fail, tests_run, busy, total;
	logic [7:0] regs [10] = '{8'h04, 8'h05, 8'h0E, 8'h0F, 8'h12, 8'h16, 8'h43, 8'h5A, 8'h5E, 8'h62};
	logic [15:0] fin [10] = '{16'hFFFC, 16'hFF00, 16'hFFFC, 16'hFFFC, 16'hFFF3, 16'hFFFD,
		16'hFFF0, 16'hFF00, 16'hFF00, 16'hFFFE};

	host_bus_model HOST (.clk(clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	shutdown_write_sequencer #(.TWO_TICK_CYCLES(TT)) DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .sequencer_running_flag(busy_f), .bias_generator_on(bias),
		.midrail_reference_on(mref), .midrail_divider_select(mdiv), .midrail_buffer_on(mbuf),
		.phones_gain_stages_on(pgain), .line_gain_stages_on(lgain),
		.left_converter_on(conv_l), .right_converter_on(conv_r),
		.processing_clock_gate(pgate), .offset_servo_lanes_on(servo),
		.phones_stage_ctrl(pstage), .line_stage_ctrl(lstage), .charge_pump_on(cpump));

	// ===========================================================
	// helpers
	function automatic int dly(input int code);
		return (((1 << code) + 8) * TT + 1) / 2;
	endfunction

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t value %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		if (HOST.hung)
			n_fail++;
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
		logic [31:0] d;
		HOST.xfer(1'b1, idx, wd, d);
		if (HOST.hung)
			complete_run();
	endtask

	task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
		logic [31:0] d;
		HOST.xfer(1'b0, idx, 16'h0, d);
		if (HOST.hung)
			complete_run();
		chk(d, {16'h0, exp});
	endtask

	// ===========================================================
	// clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ===========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		n_fail = 0;
		tests_run = 0;
		busy = 0;
		total = 13 * (1 + dly(0)) + (1 + dly(12)) + (1 + dly(9));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({hreadyout, hresp, busy_f, bias, mref, mdiv, mbuf, pgain, lgain,
			conv_l, conv_r, pgate, servo, pstage, lstage, cpump}, {2'b10, 34'h0});
		foreach (regs[i]) begin
			rd(regs[i], 16'h0000);
			wr(regs[i], 16'hFFFF);
			rd(regs[i], 16'hFFFF);
		end
		rd(8'h30, 16'h0000);
		HOST.launch();
		#1;
		for (int n = 0; n < 5000; n++) begin
			case (n)
				5: chk({lstage, pstage, bias}, {8'h77, 8'hFF, 1'b1});
				10: chk(pstage, 8'hFF);
				15: chk(pstage, 8'h77);
				35: chk({lstage, pstage}, 16'h0);
				45: chk(servo, 4'h0);
				55: chk(cpump, 1'b0);
				65: chk({conv_l, conv_r}, 2'b00);
				75: chk(pgate, 1'b0);
				85: chk({pgain, lgain}, 4'b0011);
				95: chk(lgain, 2'b00);
				105: chk(bias, 1'b0);
				115: chk({mbuf, mdiv, mref}, 4'b1110);
				4736: chk({mbuf, mdiv, mref}, 4'b1110);
				4740: chk({mbuf, mdiv, mref, busy_f}, 5'b00001);
				default: ;
			endcase
			if (busy_f === 1'b1)
				busy++;
			@(posedge clk);
			#1;
		end
		chk(busy, total);
		chk(busy_f, 1'b0);
		foreach (regs[i])
			rd(regs[i], fin[i]);
		rd(`REG_STATUS, 16'h2700);
		rd(`REG_LAUNCH, 16'h0019);
		wr(`REG_LAUNCH, 16'h0130);
		wr(`REG_LAUNCH, 16'h0119);
		#1;
		chk(busy_f, 1'b1);
		repeat (20) @(posedge clk);
		#1;
		chk(busy_f, 1'b0);
		rd(`REG_STATUS, 16'h3000);
		rd(`REG_MIDRAIL, 16'hFF00);
		complete_run();
	end
endmodule
